// ===== verilog/ledd_pkg.sv
// Purpose: Shared constants for the eight-output LED dimmer and its bus master.
// Assumes: 50 MHz system clock on both ends.
// Notes: Register indices are the device's own byte addresses on the serial bus.
package ledd_pkg;
  // System clock and dim timing: 160 Hz base period split into 256 steps.
  localparam int CLK_HZ = 50_000_000;
  localparam int DIM_BASE_HZ = 160;
  localparam int DIM_STEPS = 256;
  localparam int DIM_TICK_CYCLES = CLK_HZ / (DIM_BASE_HZ * DIM_STEPS);
  // Least width of a reset pin pulse, in ns, and its cycle count rounded up.
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Serial clock made by the master, and its quarter period in cycles.
  localparam int SCL_HZ = 100_000;
  localparam int SCL_QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);
  // Slave address: fixed upper four bits of the seven-bit address.
  localparam logic [3:0] SLAVE_ADDR_UPPER = 4'h6;
  localparam logic DIR_READ = 1'b1;
  localparam int AINC_BIT = 4;
  // Register indices.
  localparam logic [3:0] REG_PINS = 4'h0;
  localparam logic [3:0] REG_ZERO = 4'h1;
  localparam logic [3:0] REG_RATE0_PRESCALER = 4'h2;
  localparam logic [3:0] REG_DUTY0 = 4'h3;
  localparam logic [3:0] REG_RATE1_PRESCALER = 4'h4;
  localparam logic [3:0] REG_DUTY1 = 4'h5;
  localparam logic [3:0] REG_SEL_LO = 4'h6;
  localparam logic [3:0] REG_SEL_HI = 4'h7;
  localparam logic [3:0] REG_SPARE_A = 4'h8;
  localparam logic [3:0] REG_SPARE_B = 4'h9;
  localparam logic [3:0] REG_FIRST_WR = 4'h2;
  localparam logic [3:0] REG_LAST = 4'h9;
  // Reset values.
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h80;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  // Selector codes.
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ON = 2'h1;
  localparam logic [1:0] SEL_DIM_RATE_ZERO = 2'h2;
  localparam logic [1:0] SEL_DIM_RATE_ONE = 2'h3;
  // Master's Wishbone registers and fields.
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_RST_OFS = 8'h08;
  localparam int CMD_START_BIT = 8;
  localparam int CMD_STOP_BIT = 9;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_ACK_BIT = 11;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RX_LSB = 8;
endpackage : ledd_pkg

// ===== verilog/ledd_link_if.sv
// Purpose: Serial bus, reset pin and LED pins between the dimmer and its master.
// Assumes: Open-drain lines with pull-ups; the bench drives led_ext for outside loads.
// Notes: Wire levels are resolved here from each end's output and enable.
`timescale 1ns/1ns
`default_nettype none
interface ledd_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic rst_pin_n;
  logic [7:0] dev_led_o;
  logic [7:0] dev_led_oe;
  logic [7:0] led_ext;
  logic scl;
  logic sda;
  logic [7:0] led;

  // Pull-up resolution: any enabled low driver wins.
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  assign led = (~dev_led_oe | dev_led_o) & led_ext;

  modport device (input scl, input sda, input led, input rst_pin_n,
                  output dev_sda_o, output dev_sda_oe, output dev_led_o, output dev_led_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe, output rst_pin_n);
endinterface : ledd_link_if
`default_nettype wire

// ===== verilog/ledd_device.sv
// Purpose: Eight-output LED dimmer with a serial-bus slave register port.
// Assumes: All pins are asynchronous to clk_i; no clock stretching is used.
//
// Our own choice: register access over the serial bus; only the master is commanded over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module ledd_device #(
  parameter int TICK_CYCLES = ledd_pkg::DIM_TICK_CYCLES,
  parameter int RST_CYCLES = ledd_pkg::RST_PULSE_CYCLES
) (
  // Clock and power-on reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link to the bus master.
  ledd_link_if.device link,
  // User side: address straps and a copy of the LED drive state.
  input wire logic [2:0] addr_sel_i,
  output logic [7:0] led_drive_o
);
  import ledd_pkg::*;

  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_REGA, SL_WDATA, SL_RDATA} ledd_slave_t;

  // Next pointer after a byte; writes skip the two read-only registers.
  function automatic logic [3:0] ledd_next_ptr(input logic [3:0] p, input logic wr);
    if (p >= REG_LAST)
      ledd_next_ptr = wr ? REG_FIRST_WR : REG_PINS;
    else
      ledd_next_ptr = p + 4'h1;
  endfunction : ledd_next_ptr

  // Pin drive for one LED from its selector and the two dim phases.
  function automatic logic ledd_led_on(input logic [1:0] sel, input logic [1:0] dim);
    case (sel)
      SEL_OFF: ledd_led_on = 1'b0;
      SEL_ON: ledd_led_on = 1'b1;
      SEL_DIM_RATE_ZERO: ledd_led_on = dim[0];
      default: ledd_led_on = dim[1];
    endcase
  endfunction : ledd_led_on

  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [15:0] rst_cnt_reg;
  ledd_slave_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [3:0] ptr_reg;
  logic ainc_reg;
  logic rd_mode_reg;
  logic mack_reg;
  logic sda_oe_reg;
  logic [7:0] regs_reg [2:9];
  logic [15:0] tick_cnt_reg;
  logic [7:0] pre_reg [2];
  logic [7:0] step_reg [2];
  logic [7:0] led_oe_reg;

  wire logic scl_s = sync2_reg[13];
  wire logic sda_s = sync2_reg[12];
  wire logic rst_pin_s = sync2_reg[11];
  wire logic [7:0] pins_s = sync2_reg[10:3];
  wire logic [2:0] addr_s = sync2_reg[2:0];

  // Bus events from the synchronised lines.
  wire logic scl_rise = scl_s & ~scl_d_reg;
  wire logic scl_fall = ~scl_s & scl_d_reg;
  wire logic start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire logic stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire logic pin_hold = ~rst_pin_s;
  wire logic pin_reset = pin_hold & (rst_cnt_reg == 16'(RST_CYCLES));
  wire logic active = ~pin_hold & ~start_seen & ~stop_seen & (state_reg != SL_IDLE);
  wire logic byte_done = active & scl_fall & (bitcnt_reg == 4'h7);
  wire logic slot_done = active & scl_fall & (bitcnt_reg == 4'h8);
  wire logic addr_match = shift_reg[7:1] == {SLAVE_ADDR_UPPER, addr_s};
  wire logic ptr_storable = (ptr_reg >= REG_FIRST_WR) & (ptr_reg <= REG_LAST);
  wire logic wr_fire = byte_done & (state_reg == SL_WDATA) & ptr_storable;
  wire logic [7:0] rd_byte = (ptr_reg == REG_PINS) ? pins_s :
                             ptr_storable ? regs_reg[ptr_reg] : 8'h00;
  wire logic [15:0] sel_all = {regs_reg[REG_SEL_HI], regs_reg[REG_SEL_LO]};
  wire logic dim_tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);
  wire logic [1:0] dim_on = {step_reg[1] < regs_reg[REG_DUTY1], step_reg[0] < regs_reg[REG_DUTY0]};
  logic [7:0] led_next;

  // Selector decode per LED; code 00 releases the pin.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_led
      assign led_next[gi] = ledd_led_on(sel_all[2*gi+1:2*gi], dim_on);
    end
  endgenerate

  // Two-flop synchronisers for every pin; the extra scl/sda flops feed edge detection.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= 14'h3800;
      sync2_reg <= 14'h3800;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= {link.scl, link.sda, link.rst_pin_n, link.led, addr_sel_i};
      sync2_reg <= sync1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Reset pin width filter; a glitch shorter than the pulse width restores nothing.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_cnt_reg <= 16'h0000;
    else if (!pin_hold)
      rst_cnt_reg <= 16'h0000;
    else if (!pin_reset)
      rst_cnt_reg <= rst_cnt_reg + 16'h0001;
  end

  // Register storage; prescalers and duties have their own defaults.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 2; i <= 9; i++)
        regs_reg[i] <= (i == 3 || i == 5) ? DUTY_RESET : ((i == 2 || i == 4) ? PSC_RESET : OTHER_RESET);
    end
    else if (pin_reset)
    begin
      for (int i = 2; i <= 9; i++)
        regs_reg[i] <= (i == 3 || i == 5) ? DUTY_RESET : ((i == 2 || i == 4) ? PSC_RESET : OTHER_RESET);
    end
    else if (wr_fire)
      regs_reg[ptr_reg] <= shift_reg;
  end

  // Slave sequencer: samples on scl rise, changes sda only after scl fall.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= SL_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= REG_PINS;
      ainc_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (pin_hold)
    begin
      state_reg <= SL_IDLE;
      sda_oe_reg <= 1'b0;
      bitcnt_reg <= 4'h0;
    end
    else if (start_seen)
    begin
      // The clock fall that closes a start carries no bit, so the count begins one below zero.
      state_reg <= SL_ADDR;
      bitcnt_reg <= 4'hF;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_reg <= SL_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else if (state_reg != SL_IDLE)
    begin
      if (scl_rise && bitcnt_reg < 4'h8)
        shift_reg <= {shift_reg[6:0], sda_s};
      if (scl_rise && bitcnt_reg == 4'h8)
        mack_reg <= ~sda_s;
      if (byte_done)
      begin
        bitcnt_reg <= 4'h8;
        case (state_reg)
          SL_ADDR:
          begin
            sda_oe_reg <= addr_match;
            rd_mode_reg <= shift_reg[0] == DIR_READ;
            if (!addr_match)
              state_reg <= SL_IDLE;
          end
          SL_REGA:
          begin
            sda_oe_reg <= 1'b1;
            ptr_reg <= shift_reg[3:0];
            ainc_reg <= shift_reg[AINC_BIT];
          end
          SL_WDATA:
          begin
            sda_oe_reg <= 1'b1;
            if (ainc_reg)
              ptr_reg <= ledd_next_ptr(ptr_reg, 1'b1);
          end
          default:
          begin
            sda_oe_reg <= 1'b0;
            if (ainc_reg)
              ptr_reg <= ledd_next_ptr(ptr_reg, 1'b0);
          end
        endcase
      end
      else if (slot_done)
      begin
        bitcnt_reg <= 4'h0;
        if ((state_reg == SL_ADDR && rd_mode_reg) || (state_reg == SL_RDATA && mack_reg))
        begin
          state_reg <= SL_RDATA;
          tx_reg <= rd_byte;
          sda_oe_reg <= ~rd_byte[7];
        end
        else
        begin
          sda_oe_reg <= 1'b0;
          case (state_reg)
            SL_ADDR: state_reg <= SL_REGA;
            SL_REGA: state_reg <= SL_WDATA;
            SL_WDATA: state_reg <= SL_WDATA;
            default: state_reg <= SL_IDLE;
          endcase
        end
      end
      else if (active && scl_fall)
      begin
        bitcnt_reg <= bitcnt_reg + 4'h1;
        if (state_reg == SL_RDATA)
        begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          sda_oe_reg <= ~tx_reg[6];
        end
      end
    end
  end

  // Dim timing: a common step tick, then per-rate prescale and 8-bit step count.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_reg <= 16'h0000;
      for (int r = 0; r < 2; r++)
      begin
        pre_reg[r] <= 8'h00;
        step_reg[r] <= 8'h00;
      end
    end
    else
    begin
      tick_cnt_reg <= (dim_tick || pin_reset) ? 16'h0000 : tick_cnt_reg + 16'h0001;
      for (int r = 0; r < 2; r++)
      begin
        if (pin_reset)
        begin
          pre_reg[r] <= 8'h00;
          step_reg[r] <= 8'h00;
        end
        else if (dim_tick && pre_reg[r] >= regs_reg[REG_RATE0_PRESCALER + 4'(2 * r)])
        begin
          pre_reg[r] <= 8'h00;
          step_reg[r] <= step_reg[r] + 8'h01;
        end
        else if (dim_tick)
          pre_reg[r] <= pre_reg[r] + 8'h01;
      end
    end
  end

  // LED drive flops; a held reset pin forces every output released.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      led_oe_reg <= 8'h00;
    else
      led_oe_reg <= pin_hold ? 8'h00 : led_next;
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_reg;
  assign link.dev_led_o = 8'h00;
  assign link.dev_led_oe = led_oe_reg;
  assign led_drive_o = led_oe_reg;
endmodule : ledd_device
`default_nettype wire

// ===== verilog/ledd_host.sv
// Purpose: Serial-bus master for the LED dimmer, commanded over classic Wishbone.
// Assumes: No clock stretching by the slave; one byte per command.
// Notes: A command may open with a start and close with a stop; reads send the chosen ack.
`timescale 1ns/1ns
`default_nettype none
module ledd_host #(
  parameter int QUARTER = ledd_pkg::SCL_QUARTER_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Wishbone slave port.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link to the dimmer.
  ledd_link_if.host link
);
  import ledd_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} ledd_host_t;

  ledd_host_t state_reg;
  logic [1:0] phase_reg;
  logic [15:0] qcnt_reg;
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic do_stop_reg;
  logic do_read_reg;
  logic send_ack_reg;
  logic nack_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic rst_drive_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  // Bus decode; writes take effect on the edge where ack is already high.
  wire logic busy = state_reg != HS_IDLE;
  wire logic req = wb_cyc_i & wb_stb_i;
  wire logic wr_now = req & wb_we_i & ack_reg;
  wire logic cmd_go = wr_now & (wb_adr_i == HOST_CMD_OFS) & (wb_sel_i[1:0] == 2'h3) & ~busy;
  wire logic rst_wr = wr_now & (wb_adr_i == HOST_RST_OFS) & wb_sel_i[0];
  wire logic q_tick = qcnt_reg == 16'(QUARTER - 1);
  wire logic [31:0] stat_word = {16'h0000, rx_reg, 6'h00, nack_reg, busy};
  wire logic [31:0] rd_word = (wb_adr_i == HOST_STAT_OFS) ? stat_word :
                              (wb_adr_i == HOST_RST_OFS) ? {31'h00000000, rst_drive_reg} : 32'h00000000;

  // Wishbone answer one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      rst_drive_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg)
        dat_reg <= rd_word;
      if (rst_wr)
        rst_drive_reg <= wb_dat_i[0];
    end
  end

  // The slave's sda is a pin to this clock, so it is synchronised first.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end
    else
    begin
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  // Bit engine in quarter periods: data set, clock high, sample, clock low.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= HS_IDLE;
      phase_reg <= 2'h0;
      qcnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      do_stop_reg <= 1'b0;
      do_read_reg <= 1'b0;
      send_ack_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (cmd_go)
    begin
      state_reg <= wb_dat_i[CMD_START_BIT] ? HS_START : HS_BIT;
      phase_reg <= 2'h0;
      qcnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      tx_reg <= wb_dat_i[7:0];
      do_stop_reg <= wb_dat_i[CMD_STOP_BIT];
      do_read_reg <= wb_dat_i[CMD_READ_BIT];
      send_ack_reg <= wb_dat_i[CMD_ACK_BIT];
    end
    else if (busy)
    begin
      qcnt_reg <= q_tick ? 16'h0000 : qcnt_reg + 16'h0001;
      if (q_tick)
      begin
        phase_reg <= phase_reg + 2'h1;
        case (state_reg)
          HS_START:
          begin
            // Release, clock high, sda falls while high, clock low.
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default:
              begin
                scl_oe_reg <= 1'b1;
                state_reg <= HS_BIT;
                bit_reg <= 4'h0;
              end
            endcase
          end
          HS_BIT:
          begin
            case (phase_reg)
              2'h0: sda_oe_reg <= (bit_reg < 4'h8) ? (~do_read_reg & ~tx_reg[7]) : (do_read_reg & send_ack_reg);
              2'h1: scl_oe_reg <= 1'b0;
              2'h2:
              begin
                if (bit_reg < 4'h8)
                  rx_reg <= {rx_reg[6:0], sda_s2_reg};
                else if (!do_read_reg)
                  nack_reg <= sda_s2_reg;
              end
              default:
              begin
                scl_oe_reg <= 1'b1;
                tx_reg <= {tx_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == 4'h8)
                begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= do_stop_reg ? HS_STOP : HS_IDLE;
                end
              end
            endcase
          end
          HS_STOP:
          begin
            // Sda low, clock high, sda rises while high.
            case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default: state_reg <= HS_IDLE;
            endcase
          end
          default: state_reg <= HS_IDLE;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_reg;
  assign link.rst_pin_n = ~rst_drive_reg;
endmodule : ledd_host
`default_nettype wire

// ===== sim/ledd_link_monitor.sv
// Purpose: Concurrent checks on the serial link and LED enables between both ends.
// Assumes: Serial quarter period of 8 clocks, so each clock phase lasts 16 clocks.
// Notes: Watches resolved wires and each end's enables, never the bench's own drive.
`timescale 1ns/1ns
`default_nettype none
module ledd_link_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Link wires and enables.
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic rst_pin_n,
  input wire logic [7:0] dev_led_oe
);
  // One clock domain; reset clears the history of every check except AST_RESET_IDLE.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // The device may only take the data line well inside the low phase, and only leave it while scl is low.
  AST_DEV_DRIVE_LOW: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device took sda outside the scl low phase");
  AST_DEV_RELEASE_LOW: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released sda while scl high");
  AST_DEV_BIT_HOLD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device dropped its bit too early");
  // Only the master frames a transfer.
  AST_START_BY_HOST: assert property (scl && $past(scl) && $fell(sda) |-> host_sda_oe)
    else $error("start seen without master drive");
  // Clock phases keep their length so each bit is sampled once.
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  // A held reset pin releases every device output within the sync delay.
  AST_RST_PIN_QUIET: assert property (!rst_pin_n [*5] |-> !dev_sda_oe && dev_led_oe == 8'h00)
    else $error("device drives while its reset pin is low");
  // Power-on reset leaves every device output released; checked from the second clock edge in reset,
  // because a reset that is low from time zero only reaches the flops at the first clock edge.
  AST_RESET_IDLE: assert property (disable iff (1'b0) !resetn_i ##1 !resetn_i |-> !dev_sda_oe && dev_led_oe == 8'h00)
    else $error("device drives during power-on reset");

  // Main scenarios reached.
  cover property ($rose(dev_sda_oe));
  cover property (!rst_pin_n [*5]);
  cover property (scl && $fell(sda));
endmodule : ledd_link_monitor
`default_nettype wire

// ===== sim/tb_i2c_eight_led_dimmer.sv
// Purpose: Self-checking bench joining the serial master to the LED dimmer.
// Assumes: Shortened counts: dim tick 4, reset pin width 4, serial quarter 8.
// Notes: Rows write one register alone, then read it back through a repeated start.
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_eight_led_dimmer;
  import ledd_pkg::*;
  typedef struct packed {logic [3:0] idx; logic [7:0] w; logic [7:0] e;} ledd_row_t;
  localparam logic [11:0] S = 12'h100;
  localparam logic [11:0] P = 12'h200;
  localparam logic [11:0] RD = 12'h400;
  localparam logic [11:0] AK = 12'h800;
  localparam logic [7:0] DEV_W = {SLAVE_ADDR_UPPER, 3'h5, 1'b0};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] st;
  logic ack;
  logic [7:0] drive;
  logic [7:0] dq[$];
  logic [7:0] got[$];
  int mismatches = 0;
  int total_checks = 0;
  int n;
  int m;
  ledd_row_t rows [11] = '{'{4'h0, 8'h55, 8'hA5}, '{4'h1, 8'hFF, 8'h00}, '{4'h2, 8'h01, 8'h01},
    '{4'h3, 8'h40, 8'h40}, '{4'h4, 8'h03, 8'h03}, '{4'h5, 8'h00, 8'h00}, '{4'h6, 8'h1B, 8'h1B},
    '{4'h7, 8'h40, 8'h40}, '{4'h8, 8'h5A, 8'h5A}, '{4'h9, 8'hA5, 8'hA5}, '{4'hA, 8'h77, 8'h00}};

  ledd_link_if link ();
  ledd_device #(.TICK_CYCLES(4), .RST_CYCLES(4)) u_ledd_device (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(link), .addr_sel_i(3'h5), .led_drive_o(drive));
  ledd_host #(.QUARTER(8)) u_ledd_host (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
  ledd_link_monitor u_ledd_link_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .scl(link.scl), .sda(link.sda),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .rst_pin_n(link.rst_pin_n),
    .dev_led_oe(link.dev_led_oe));

  // 50 MHz system clock.
  always #10 clk_i = ~clk_i;

  // Closing report; every path that ends the run comes here.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // A spent wait bound is a failure, so a hang never runs on.
  task automatic guard(input int i, input int lim);
    if (i >= lim)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : guard

  // Four-state compare, so an unknown never passes as a match.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  // Classic Wishbone cycle held until ack; the answer is taken at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    guard(i, 20);
    st = rdat;
    cyc <= 1'b0;
  endtask : wb

  // One serial byte: command the master, then poll status until it is idle.
  task automatic cmd(input logic [11:0] c);
    int i;
    wb(1'b1, HOST_CMD_OFS, {20'h0, c});
    i = 0;
    do
    begin
      wb(1'b0, HOST_STAT_OFS, 32'h0);
      i++;
    end
    while (st[STAT_BUSY_BIT] !== 1'b0 && i < 500);
    guard(i, 500);
  endtask : cmd

  // Whole transfer: address, register byte, queued data, then nrd reads after a repeated start.
  task automatic xfer(input logic [7:0] rb, input int nrd);
    cmd(S | {4'h0, DEV_W});
    chk(st[STAT_NACK_BIT], 1'b0);
    cmd({4'h0, rb});
    foreach (dq[i])
    begin
      cmd((i == dq.size() - 1 && nrd == 0 ? P : 12'h000) | {4'h0, dq[i]});
      chk(st[STAT_NACK_BIT], 1'b0);
    end
    if (nrd > 0)
      cmd(S | {4'h0, DEV_W | 8'h01});
    got = {};
    for (int i = 0; i < nrd; i++)
    begin
      cmd(RD | (i == nrd - 1 ? P : AK));
      got.push_back(st[STAT_RX_LSB +: 8]);
    end
    dq = {};
  endtask : xfer

  // Main sequence: reset, table rows, then the awkward cases.
  initial
  begin
    link.led_ext <= 8'hA5;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk(drive, 8'h00);
    repeat (4) @(posedge clk_i);
    xfer(8'h13, 1);
    chk(got[0], DUTY_RESET);
    foreach (rows[k])
    begin
      dq = '{rows[k].w};
      xfer({4'h0, rows[k].idx}, 0);
      xfer({4'h0, rows[k].idx}, 1);
      chk(got[0], rows[k].e);
    end
    // One full rate-0 period: LED1 dims, LED2 and LED7 on, LED0 on rate 1 at zero duty stays off.
    n = 0;
    m = 0;
    repeat (2 * DIM_STEPS * 4)
    begin
      @(posedge clk_i);
      n += int'(drive[1] === 1'b1);
      m += int'((drive & 8'h8D) === 8'h84);
    end
    chk(n, 2 * 8'h40 * 4);
    chk(m, 2 * DIM_STEPS * 4);
    dq = '{8'h11, 8'h22};
    xfer(8'h08, 0);
    xfer(8'h18, 2);
    chk({got[0], got[1]}, 16'h22A5);
    dq = '{8'h66, 8'h07};
    xfer(8'h19, 0);
    link.led_ext <= 8'h3C;
    xfer(8'h19, 4);
    chk({got[0], got[2], got[3]}, 24'h660007);
    chk(got[1] & 8'hFD, 8'h38);
    cmd(S | 12'h0C0);
    chk(st[STAT_NACK_BIT], 1'b1);
    cmd(P | 12'h0FF);
    // Reset pin held well past its minimum width, then released.
    wb(1'b1, HOST_RST_OFS, 32'h1);
    repeat (20) @(posedge clk_i);
    chk({link.rst_pin_n, drive}, 9'h000);
    wb(1'b1, HOST_RST_OFS, 32'h0);
    repeat (10) @(posedge clk_i);
    xfer(8'h12, 4);
    chk({got[0], got[1], got[2], got[3]}, 32'h00800080);
    report_and_stop();
  end
endmodule : tb_i2c_eight_led_dimmer
`default_nettype wire
